// ===== hw/stack_ea_regs.vh
// Constants for the stack limit and effective address block
`ifndef STACK_EA_REGS_VH
`define STACK_EA_REGS_VH
// Address floor below which the stack underflows (special register space)
`define STK_UNDERFLOW_FLOOR 16'h0800
// Operand field widths
`define FILE_ADDR_W 13
`define LIT5_W 5
`define LIT10_W 10
`define OFFSET_REG_W 4
`define BRANCH_LIT_W 16
`define DISABLE_LIT_W 14
// Working register index used as the stack pointer
`define STACK_PTR_IDX 4'h0f
// Working register index used as the default working register
`define DEFAULT_DEFAULT_WORKING_REGISTER_IDX 4'h0
// Addressing mode encodings
`define MODE_DIRECT 3'h0
`define MODE_INDIRECT 3'h1
`define MODE_POST 3'h2
`define MODE_PRE 3'h3
`define MODE_INDEXED 3'h4
`define MODE_LIT_OFFSET 3'h5
`define MODE_FILE 3'h6
`define MODE_LITERAL 3'h7
// Stack operation encodings
`define STK_NONE 2'h0
`define STK_PUSH 2'h1
`define STK_POP 2'h2
// Push word sources
`define PUSH_DATA 2'h0
`define PUSH_CALL 2'h1
`define PUSH_EXC 2'h2
// Width of the high program counter portion kept on a push
`define PC_HI_W 7
`endif

// ===== hw/ea_adder.v
// Effective address former for one operand side
`default_nettype none
`include "stack_ea_regs.vh"
module ea_adder (
    input wire [2:0] mode_i,      // Addressing mode
    input wire [15:0] ptr_i,      // Pointer register contents
    input wire [15:0] offs_i,     // Offset register contents
    input wire [15:0] mod_i,      // Signed modify constant
    input wire [15:0] lit_i,      // Literal offset or address
    output reg [15:0] ea_o,       // Effective address
    output reg [15:0] ptr_new_o,  // Pointer value to write back
    output reg ptr_wr_o           // Pointer write-back wanted
);
    // ----------------------------------------------------------------
    // Address selection
    // ----------------------------------------------------------------
    always @* begin
        ea_o = ptr_i;
        ptr_new_o = ptr_i;
        ptr_wr_o = 1'b0;
        case (mode_i)
            `MODE_INDIRECT: ea_o = ptr_i;
            `MODE_POST: begin
                ea_o = ptr_i;
                ptr_new_o = ptr_i + mod_i;
                ptr_wr_o = 1'b1;
            end
            `MODE_PRE: begin
                ea_o = ptr_i + mod_i;
                ptr_new_o = ptr_i + mod_i;
                ptr_wr_o = 1'b1;
            end
            `MODE_INDEXED: ea_o = ptr_i + offs_i;
            `MODE_LIT_OFFSET: ea_o = ptr_i + lit_i;
            // File register direct: 13-bit near address
            `MODE_FILE: ea_o = {3'h0, lit_i[`FILE_ADDR_W-1:0]};
            default: ea_o = ptr_i;
        endcase
    end
endmodule // ea_adder
`default_nettype wire

// ===== hw/stack_ea_unit.v
// Software stack, stack limit check and effective address generation
`default_nettype none
`include "stack_ea_regs.vh"
module stack_ea_unit (
    input wire clk_i,                  // Core clock, 25 MHz
    input wire rst_b_i,                // Async reset, active low
    input wire instr_vld_i,            // Decoded instruction valid
    input wire [2:0] src_mode_i,       // Source addressing mode
    input wire [2:0] dst_mode_i,       // Destination addressing mode
    input wire [3:0] src_reg_i,        // Source pointer register index
    input wire [3:0] dst_reg_i,        // Destination pointer index
    input wire [3:0] offset_reg_i,     // Shared offset register index
    input wire [3:0] base_reg_i,       // First operand register index
    input wire [15:0] src_mod_i,       // Signed source modify constant
    input wire [15:0] dst_mod_i,       // Signed destination modify
    input wire [15:0] lit_i,           // Literal or file address field
    input wire lit10_i,                // Literal is 10 bits, else 5
    input wire file_to_default_working_register_i,         // File result goes to register 0
    input wire [1:0] stk_op_i,         // Stack push or pop request
    input wire [1:0] push_src_i,       // Word source for a push
    input wire [15:0] push_data_i,     // Data word for a plain push
    input wire [22:0] pc_i,            // Program counter
    input wire [7:0] status_low_byte_i, // Low status byte
    input wire reg_wr_i,               // Working register write
    input wire [3:0] reg_wr_idx_i,     // Written register index
    input wire [15:0] reg_wr_data_i,   // Written register value
    input wire limit_wr_i,             // Stack limit write
    input wire [15:0] limit_data_i,    // Stack limit write value
    input wire [15:0] branch_lit_i,    // Branch displacement literal
    input wire [13:0] disable_lit_i,   // Interrupt disable count field
    output reg [15:0] src_ea_o,        // Source effective address
    output reg [15:0] dst_ea_o,        // Destination effective address
    output reg [15:0] op1_o,           // First operand value
    output reg [15:0] op2_o,           // Second operand value
    output reg [3:0] result_idx_o,     // Result register index
    output reg mem_wr_o,               // Data memory write strobe
    output reg mem_rd_o,               // Data memory read strobe
    output reg [15:0] mem_addr_o,      // Data memory address
    output reg [15:0] mem_wdata_o,     // Data memory write word
    output reg [22:0] branch_tgt_o,    // Branch target
    output reg [13:0] disable_cnt_o,   // Interrupt disable count
    output reg [15:0] stack_ptr_o,     // Stack pointer value
    output reg stack_trap_o            // Stack error trap request
);
    // ----------------------------------------------------------------
    // Working register file
    // ----------------------------------------------------------------
    reg [15:0] default_working_register_q [0:15];    // Working registers, 15 is stack ptr
    reg [15:0] stack_limit_q;    // Limit, not reset
    wire [15:0] src_ea;          // Formed source address
    wire [15:0] dst_ea;          // Formed destination address
    wire [15:0] src_ptr_new;     // Source pointer write-back
    wire [15:0] dst_ptr_new;     // Destination pointer write-back
    wire src_ptr_wr;             // Source pointer update wanted
    wire dst_ptr_wr;             // Destination pointer update wanted
    reg [15:0] sp_d;             // Next stack pointer
    reg [15:0] push_word;        // Word placed on the stack
    reg [15:0] stk_addr;         // Stack access address
    reg trap_d;                  // Stack fault this cycle
    reg [15:0] op2_d;            // Second operand selection
    integer i;

    // Stack pointer addressed as a pointer
    function is_sp;
        input [3:0] idx;
        begin
            is_sp = (idx == `STACK_PTR_IDX);
        end
    endfunction

    // Pointer-based mode, which forms an address from a register
    function is_ptr_mode;
        input [2:0] m;
        begin
            is_ptr_mode = (m == `MODE_INDIRECT) || (m == `MODE_POST) ||
                (m == `MODE_PRE) || (m == `MODE_INDEXED) ||
                (m == `MODE_LIT_OFFSET);
        end
    endfunction

    // Address out of the stack window: past limit or into SFR space
    function sp_fault;
        input [15:0] a;
        input [15:0] lim;
        begin
            sp_fault = (a > lim) || (a < `STK_UNDERFLOW_FLOOR);
        end
    endfunction

    // ----------------------------------------------------------------
    // Address formers, offset register shared by both sides
    // ----------------------------------------------------------------
    ea_adder u_src (
        .mode_i(src_mode_i),
        .ptr_i(default_working_register_q[src_reg_i]),
        .offs_i(default_working_register_q[offset_reg_i]),
        .mod_i(src_mod_i),
        .lit_i(lit_i),
        .ea_o(src_ea),
        .ptr_new_o(src_ptr_new),
        .ptr_wr_o(src_ptr_wr)
    );

    ea_adder u_dst (
        .mode_i(dst_mode_i),
        .ptr_i(default_working_register_q[dst_reg_i]),
        .offs_i(default_working_register_q[offset_reg_i]),
        .mod_i(dst_mod_i),
        .lit_i(lit_i),
        .ea_o(dst_ea),
        .ptr_new_o(dst_ptr_new),
        .ptr_wr_o(dst_ptr_wr)
    );

    // ----------------------------------------------------------------
    // Stack pointer arithmetic and limit check
    // ----------------------------------------------------------------
    always @* begin
        sp_d = default_working_register_q[`STACK_PTR_IDX];
        stk_addr = default_working_register_q[`STACK_PTR_IDX];
        trap_d = 1'b0;
        // Word pushed depends on who pushes
        case (push_src_i)
            `PUSH_CALL: push_word = {{(16-`PC_HI_W){1'b0}},
                pc_i[22:16]};
            `PUSH_EXC: push_word = {status_low_byte_i, 1'b0,
                pc_i[22:16]};
            default: push_word = push_data_i;
        endcase
        if (instr_vld_i) begin
            case (stk_op_i)
                `STK_PUSH: begin
                    // Write at current free word, then step up
                    stk_addr = default_working_register_q[`STACK_PTR_IDX];
                    sp_d = default_working_register_q[`STACK_PTR_IDX] + 16'h0002;
                    trap_d = sp_fault(stk_addr, stack_limit_q);
                end
                `STK_POP: begin
                    // Step down first, then read
                    sp_d = default_working_register_q[`STACK_PTR_IDX] - 16'h0002;
                    stk_addr = sp_d;
                    trap_d = sp_fault(stk_addr, stack_limit_q);
                end
                default: begin
                    // Pointer write-back to the stack pointer moves it too,
                    // so the reported pointer follows the register file
                    if (is_sp(src_reg_i) && src_ptr_wr)
                        sp_d = src_ptr_new;
                    if (is_sp(dst_reg_i) && dst_ptr_wr)
                        sp_d = dst_ptr_new;
                    // Any other pointer use of the stack pointer
                    if (is_sp(src_reg_i) && is_ptr_mode(src_mode_i) &&
                        sp_fault(src_ea, stack_limit_q))
                        trap_d = 1'b1;
                    if (is_sp(dst_reg_i) && is_ptr_mode(dst_mode_i) &&
                        sp_fault(dst_ea, stack_limit_q))
                        trap_d = 1'b1;
                end
            endcase
        end
    end

    // Second operand: register, memory address, or short literal
    always @* begin
        if (src_mode_i == `MODE_LITERAL) begin
            if (lit10_i)
                op2_d = {6'h00, lit_i[`LIT10_W-1:0]};
            else
                op2_d = {11'h000, lit_i[`LIT5_W-1:0]};
        end else if (src_mode_i == `MODE_DIRECT) begin
            op2_d = default_working_register_q[src_reg_i];
        end else begin
            op2_d = src_ea;
        end
    end

    // ----------------------------------------------------------------
    // Register update; pointer write-back loses to explicit writes
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < 16; i = i + 1)
                default_working_register_q[i] <= 16'h0000;
        end else if (instr_vld_i) begin
            if (src_ptr_wr)
                default_working_register_q[src_reg_i] <= src_ptr_new;
            if (dst_ptr_wr)
                default_working_register_q[dst_reg_i] <= dst_ptr_new;
            if (stk_op_i != `STK_NONE)
                default_working_register_q[`STACK_PTR_IDX] <= sp_d;
            if (reg_wr_i)
                default_working_register_q[reg_wr_idx_i] <= reg_wr_data_i;
        end else if (reg_wr_i) begin
            default_working_register_q[reg_wr_idx_i] <= reg_wr_data_i;
        end
    end

    // Limit has no reset; bit zero always clear
    always @(posedge clk_i) begin
        if (limit_wr_i)
            stack_limit_q <= {limit_data_i[15:1], 1'b0};
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            src_ea_o <= 16'h0000;
            dst_ea_o <= 16'h0000;
            op1_o <= 16'h0000;
            op2_o <= 16'h0000;
            result_idx_o <= 4'h0;
            mem_wr_o <= 1'b0;
            mem_rd_o <= 1'b0;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            branch_tgt_o <= 23'h00_0000;
            disable_cnt_o <= 14'h0000;
            stack_ptr_o <= 16'h0000;
            stack_trap_o <= 1'b0;
        end else begin
            src_ea_o <= src_ea;
            dst_ea_o <= dst_ea;
            op1_o <= default_working_register_q[base_reg_i];
            op2_o <= op2_d;
            // File instructions target register zero or the file
            result_idx_o <= file_to_default_working_register_i ? `DEFAULT_DEFAULT_WORKING_REGISTER_IDX :
                dst_reg_i;
            mem_wr_o <= instr_vld_i && (stk_op_i == `STK_PUSH);
            mem_rd_o <= instr_vld_i && (stk_op_i == `STK_POP);
            mem_addr_o <= stk_addr;
            mem_wdata_o <= push_word;
            // PC plus signed word displacement
            branch_tgt_o <= pc_i + {{6{branch_lit_i[15]}},
                branch_lit_i, 1'b0};
            disable_cnt_o <= disable_lit_i;
            // Explicit register write wins, as in the register file
            stack_ptr_o <= (reg_wr_i && is_sp(reg_wr_idx_i)) ?
                reg_wr_data_i : sp_d;
            stack_trap_o <= trap_d;
        end
    end
endmodule // stack_ea_unit
`default_nettype wire

// ===== tb/stack_ea_unit_sva.sv
// Concurrent checks on the stack and address unit ports
`default_nettype none
`include "stack_ea_regs.vh"
module stack_ea_checker (
    input wire logic clk_i, // Clock
    input wire logic rst_b_i, // Reset
    input wire logic instr_vld_i, // Valid
    input wire logic [2:0] src_mode_i, // Mode
    input wire logic [3:0] src_reg_i, // Pointer
    input wire logic [15:0] src_mod_i, // Modify
    input wire logic [1:0] stk_op_i, // Stack op
    input wire logic [1:0] push_src_i, // Push source
    input wire logic [22:0] pc_i, // Counter
    input wire logic [7:0] status_low_byte_i, // Status
    input wire logic limit_wr_i, // Limit write
    input wire logic [15:0] limit_data_i, // Limit
    input wire logic [15:0] branch_lit_i, // Branch
    input wire logic [15:0] src_ea_o, // Source address
    input wire logic mem_wr_o, // Write
    input wire logic mem_rd_o, // Read
    input wire logic [15:0] mem_addr_o, // Address
    input wire logic [15:0] mem_wdata_o, // Data
    input wire logic [22:0] branch_tgt_o, // Target
    input wire logic [15:0] stack_ptr_o, // Pointer out
    input wire logic stack_trap_o // Trap
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------
    // Helpers
    // ------------------
    logic [15:0] lim_q; // Shadow limit, unreset like the real one
    logic psh, pop, sp_src; // Request decodes
    logic [15:0] call_w, exc_w; // Expected push words
    logic [22:0] bofs; // Byte displacement of a branch
    assign psh = instr_vld_i && stk_op_i == `STK_PUSH;
    assign pop = instr_vld_i && stk_op_i == `STK_POP;
    assign sp_src = instr_vld_i && src_reg_i == `STACK_PTR_IDX;
    assign call_w = {9'h000, pc_i[22:16]};
    assign exc_w = {status_low_byte_i, 1'b0, pc_i[22:16]};
    assign bofs = {{6{branch_lit_i[15]}}, branch_lit_i, 1'b0};
    // Bit zero dropped so the limit stays word aligned
    always_ff @(posedge clk_i)
        if (limit_wr_i) lim_q <= {limit_data_i[15:1], 1'b0};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    property p_push_addr;
        psh |=> mem_wr_o && mem_addr_o == $past(stack_ptr_o)
            && stack_ptr_o == mem_addr_o + 16'h0002;
    endproperty
    a_push_addr: assert property (p_push_addr)
        else $error("push address or pointer step wrong");
    property p_pop_addr;
        pop |=> mem_rd_o && stack_ptr_o == mem_addr_o
            && mem_addr_o == $past(stack_ptr_o) - 16'h0002;
    endproperty
    a_pop_addr: assert property (p_pop_addr)
        else $error("pop address or pointer step wrong");
    property p_call_word;
        psh && push_src_i == `PUSH_CALL |=> mem_wdata_o == $past(call_w);
    endproperty
    a_call_word: assert property (p_call_word)
        else $error("call push word wrong");
    property p_exc_word;
        psh && push_src_i == `PUSH_EXC |=> mem_wdata_o == $past(exc_w);
    endproperty
    a_exc_word: assert property (p_exc_word)
        else $error("exception push word wrong");
    property p_fault;
        psh || pop |=> stack_trap_o ==
            (mem_addr_o > lim_q || mem_addr_o < `STK_UNDERFLOW_FLOOR);
    endproperty
    a_fault: assert property (p_fault)
        else $error("stack trap does not match limit check");
    property p_trap_cause;
        stack_trap_o |-> $past(instr_vld_i);
    endproperty
    a_trap_cause: assert property (p_trap_cause)
        else $error("trap without an instruction");
    property p_post;
        sp_src && src_mode_i == `MODE_POST |=> src_ea_o == $past(stack_ptr_o)
            && stack_ptr_o == $past(stack_ptr_o) + $past(src_mod_i);
    endproperty
    a_post: assert property (p_post)
        else $error("post modify address wrong");
    property p_pre;
        sp_src && src_mode_i == `MODE_PRE |=> stack_ptr_o == src_ea_o
            && src_ea_o == $past(stack_ptr_o) + $past(src_mod_i);
    endproperty
    a_pre: assert property (p_pre)
        else $error("pre modify address wrong");
    property p_branch;
        instr_vld_i |=> branch_tgt_o == $past(pc_i) + $past(bofs);
    endproperty
    a_branch: assert property (p_branch)
        else $error("branch target wrong");
endmodule // stack_ea_checker
bind stack_ea_unit stack_ea_checker chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .instr_vld_i(instr_vld_i), .src_mode_i(src_mode_i), .src_reg_i(src_reg_i),
    .src_mod_i(src_mod_i), .stk_op_i(stk_op_i), .push_src_i(push_src_i),
    .pc_i(pc_i), .status_low_byte_i(status_low_byte_i),
    .limit_wr_i(limit_wr_i), .limit_data_i(limit_data_i),
    .branch_lit_i(branch_lit_i), .src_ea_o(src_ea_o), .mem_wr_o(mem_wr_o),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .branch_tgt_o(branch_tgt_o), .stack_ptr_o(stack_ptr_o),
    .stack_trap_o(stack_trap_o));
`default_nettype wire

// ===== tb/data_mem_model.sv
// Behavioural data memory answering the unit's strobes
`default_nettype none
module data_mem_model (
    input wire logic clk_i, // Clock
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [15:0] addr_i, // Byte address
    input wire logic [15:0] wdata_i, // Write word
    output logic [15:0] rdata_o // Last word read
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem_q [0:4095]; // Small window, upper bits alias
    // Word wide store, read lands one edge after the strobe
    always @(posedge clk_i) begin
        if (wr_i) mem_q[addr_i[12:1]] <= wdata_i;
        if (rd_i) rdata_o <= mem_q[addr_i[12:1]];
    end
endmodule // data_mem_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the stack and address unit
`default_nettype none
`include "stack_ea_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, vld = 0, lit10 = 0, to_w = 0;
    logic reg_wr = 0, lim_wr = 0;
    logic [2:0] sm = 0, dm = 0;
    logic [3:0] sr = 0, dr = 0, offr = 0, br = 0, widx = 0;
    logic [1:0] op = 0, psrc = 0;
    logic [15:0] smod = 0, dmod = 0, lit = 0, pdat = 0, wdat = 0;
    logic [15:0] ldat = 0, blit = 0;
    logic [22:0] pc = 0;
    logic [7:0] slb = 0;
    logic [13:0] dlit = 0;
    wire [15:0] sea, dea, op1, op2, maddr, mwd, sp, rdat;
    wire [3:0] ridx;
    wire mwr, mrd, trap;
    wire [22:0] btgt;
    wire [13:0] dcnt;
    int failures = 0, check_count = 0;
    always #20 clk = ~clk;
    stack_ea_unit dut_u (.clk_i(clk), .rst_b_i(rst_b), .instr_vld_i(vld),
        .src_mode_i(sm), .dst_mode_i(dm), .src_reg_i(sr), .dst_reg_i(dr),
        .offset_reg_i(offr), .base_reg_i(br), .src_mod_i(smod),
        .dst_mod_i(dmod), .lit_i(lit), .lit10_i(lit10), .file_to_default_working_register_i(to_w),
        .stk_op_i(op), .push_src_i(psrc), .push_data_i(pdat), .pc_i(pc),
        .status_low_byte_i(slb), .reg_wr_i(reg_wr), .reg_wr_idx_i(widx),
        .reg_wr_data_i(wdat), .limit_wr_i(lim_wr), .limit_data_i(ldat),
        .branch_lit_i(blit), .disable_lit_i(dlit), .src_ea_o(sea),
        .dst_ea_o(dea), .op1_o(op1), .op2_o(op2), .result_idx_o(ridx),
        .mem_wr_o(mwr), .mem_rd_o(mrd), .mem_addr_o(maddr),
        .mem_wdata_o(mwd), .branch_tgt_o(btgt), .disable_cnt_o(dcnt),
        .stack_ptr_o(sp), .stack_trap_o(trap));
    data_mem_model mem_u (.clk_i(clk), .wr_i(mwr), .rd_i(mrd),
        .addr_i(maddr), .wdata_i(mwd), .rdata_o(rdat));
    // ------------------
    // Shared tasks
    // ------------------
    task automatic stop_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [22:0] exp, got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Inputs move on the falling edge, away from sampling
    task automatic tick;
        @(negedge clk);
    endtask
    task automatic idle;
        vld = 0;
        op = 0;
        sm = 0;
        dm = 0;
        tick;
    endtask
    task automatic default_working_register(input logic [3:0] i, input logic [15:0] d);
        reg_wr = 1;
        widx = i;
        wdat = d;
        tick;
        reg_wr = 0;
    endtask
    // Valid is left high so requests can run back to back
    task automatic stk(input logic [1:0] o, s, input logic [15:0] a, w,
                       input logic t);
        vld = 1;
        op = o;
        psrc = s;
        pdat = (s == `PUSH_DATA) ? w : ~w;
        tick;
        chk("addr", a, maddr);
        chk("trap", t, trap);
        chk("sp", (o == `STK_PUSH) ? a + 16'h0002 : a, sp);
        if (o == `STK_PUSH) chk("wdata", w, mwd);
    endtask
    task automatic ea(input logic [2:0] s, d, input logic [15:0] m);
        vld = 1;
        sm = s;
        dm = d;
        sr = 4'hf;
        dr = 4'hf;
        offr = 4'h3;
        smod = m;
        tick;
    endtask
    // ------------------
    // Scenarios
    // ------------------
    task automatic t_stack;
        lim_wr = 1;
        ldat = 16'h1FFF;
        tick;
        lim_wr = 0;
        default_working_register(4'hf, 16'h1FFA);
        pc = 23'h5A_1234;
        slb = 8'hC3;
        stk(`STK_PUSH, `PUSH_DATA, 16'h1FFA, 16'h1234, 0);
        stk(`STK_PUSH, `PUSH_CALL, 16'h1FFC, 16'h005A, 0);
        stk(`STK_PUSH, `PUSH_EXC, 16'h1FFE, 16'hC35A, 0);
        stk(`STK_PUSH, `PUSH_DATA, 16'h2000, 16'hBEEF, 1);
        stk(`STK_POP, `PUSH_DATA, 16'h2000, 16'h0000, 1);
        stk(`STK_POP, `PUSH_DATA, 16'h1FFE, 16'h0000, 0);
        stk(`STK_POP, `PUSH_DATA, 16'h1FFC, 16'h0000, 0);
        chk("pop word", 16'hC35A, rdat);
        idle;
        chk("pop word", 16'h005A, rdat);
        default_working_register(4'hf, 16'h0802);
        stk(`STK_POP, `PUSH_DATA, 16'h0800, 16'h0000, 0);
        stk(`STK_POP, `PUSH_DATA, 16'h07FE, 16'h0000, 1);
        idle;
        chk("trap", 1'b0, trap);
    endtask
    task automatic t_modes;
        default_working_register(4'hf, 16'h1000);
        default_working_register(4'h3, 16'h0010);
        ea(`MODE_POST, `MODE_DIRECT, 16'h0002);
        chk("post ea", 16'h1000, sea);
        chk("post sp", 16'h1002, sp);
        ea(`MODE_PRE, `MODE_DIRECT, 16'hFFFE);
        chk("pre ea", 16'h1000, sea);
        chk("pre sp", 16'h1000, sp);
        lit = 16'h0020;
        ea(`MODE_INDEXED, `MODE_LIT_OFFSET, 16'h0000);
        chk("index ea", 16'h1010, sea);
        chk("lit ea", 16'h1020, dea);
        lit = 16'hFFFF;
        to_w = 1;
        br = 4'h3;
        ea(`MODE_FILE, `MODE_DIRECT, 16'h0000);
        chk("file ea", 16'h1FFF, sea);
        chk("result", 4'h0, ridx);
        chk("op1", 16'h0010, op1);
        ea(`MODE_LITERAL, `MODE_DIRECT, 16'h0000);
        chk("lit5", 16'h001F, op2);
        lit10 = 1;
        ea(`MODE_LITERAL, `MODE_DIRECT, 16'h0000);
        chk("lit10", 16'h03FF, op2);
        idle;
    endtask
    task automatic t_branch;
        pc = 23'h00_1000;
        blit = 16'hFFFE;
        dlit = 14'h3FFF;
        vld = 1;
        tick;
        chk("target", 23'h00_0FFC, btgt);
        chk("disable", 14'h3FFF, dcnt);
        idle;
    endtask
    // Watchdog: the whole run needs only about a microsecond
    initial begin
        #50us;
        failures++;
        stop_test;
    end
    initial begin
        repeat (3) tick;
        rst_b = 1;
        chk("reset sp", 16'h0000, sp);
        chk("reset trap", 1'b0, trap);
        t_stack;
        t_modes;
        t_branch;
        stop_test;
    end
endmodule // testbench
`default_nettype wire
